/* File: common/hub_cfg_regs.svh */
/*
  hub_cfg_regs.svh: offsets, field positions, reset values and masks of the
  port configuration register bank.
  assumes: included by bare name by the register bank module.
*/
`ifndef HUB_CFG_REGS_SVH
`define HUB_CFG_REGS_SVH

// register offsets on the configuration write/read port
`define OFS_ASSIGN_LED_STRING_CONFIG 8'h08
`define OFS_FIXED_DEVICE_PORTS 8'h09
`define OFS_SELF_POWERED_PORT_OFF 8'h0a
`define OFS_BUS_POWERED_PORT_OFF 8'h0b

// field positions inside assign_led_string_config
`define STYLE_MSB 7
`define STYLE_LSB 6
`define SOURCE_BIT 5
`define INDICATOR_MSB 2
`define INDICATOR_LSB 1
`define STRING_BIT 0

// reset value shared by all four registers
`define CFG_RESET 8'h00

// writable bits; everything else reads zero
`define CFG3_MASK 8'he7
`define PORT_MASK 8'h1e

`endif

/* File: common/hub_cfg_pkg.sv */
/*
  hub_cfg_pkg.sv: types shared by the port configuration register bank.
  assumes: nothing beyond the companion _regs.svh header.
*/
package hub_cfg_pkg;

  // port-assignment interface style
  typedef enum logic [1:0]
  {
    style_programmable,
    style_direct_level,
    style_edge_no_unassigned,
    style_edge_unassigned
  } ownership_style_e;

  // indicator scheme
  typedef enum logic [1:0]
  {
    led_usb,
    led_owner_speed,
    led_owner_basic
  } indicator_scheme_e;

  // one configuration write/read request
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_s;

  // decoded settings handed to the hub core
  typedef struct packed
  {
    ownership_style_e style;
    logic from_registers;
    indicator_scheme_e scheme;
    logic string_enable;
    logic [3:0] fixed_ports;
    logic [3:0] ports_off;
    logic compound;
  } hub_settings_s;

endpackage

/* File: verilog/strap_sync.sv */
/*
  strap_sync.sv: two-flop synchroniser for the four strap pins.
  assumes: pins are static levels from outside the mclk domain.
*/
`timescale 1ns/1ps
module strap_sync
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] pins,
  output logic [3:0] synced
);

  logic [3:0] meta;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 4'h0;
      synced <= 4'h0;
    end
    else if (clk_en)
    begin
      meta <= pins;
      synced <= meta;
    end
  end

endmodule // strap_sync

/* File: verilog/strap_decode.sv */
/*
  strap_decode.sv: turns two-bit strap codes into port masks (ports 1..4
  at bits 1..4).
  assumes: combinational; caller registers the result.
*/
`timescale 1ns/1ps
module strap_decode
(
  input wire logic [1:0] fixed_code,
  input wire logic [1:0] off_code,
  output logic [7:0] fixed_mask,
  output logic [7:0] off_mask
);

  // fixed code n marks ports 1..n (0 = none)
  always_comb
  begin
    case (fixed_code)
      2'b01: fixed_mask = 8'h02;
      2'b10: fixed_mask = 8'h06;
      2'b11: fixed_mask = 8'h0e;
      default: fixed_mask = 8'h00;
    endcase
  end

  // disable code n turns off the top n ports, descending from port 4
  always_comb
  begin
    case (off_code)
      2'b01: off_mask = 8'h10;
      2'b10: off_mask = 8'h18;
      2'b11: off_mask = 8'h1c;
      default: off_mask = 8'h00;
    endcase
  end

endmodule // strap_decode

/* File: verilog/hub_port_config_registers.sv */
/*
  hub_port_config_registers.sv: four configuration registers of the hub
  port block plus the latched settings handed to the hub core.
  assumes: loader (eeprom or smbus engine) writes over a one-cycle strobe
  port on mclk; straps are static pins; hub core pulses apply_load before
  attaching upstream.
*/
//
// Function
// - style 00: three wires select one of eight port-host setups
// - style 01: four wires, level of each sets its port owner
// - style 10: four edge-triggered wires, never unassigned
// - style 11: four edge-triggered wires, unassigned state allowed
// - source bit 5: 0 takes pins, 1 takes stored assignment registers
// - reserved bits always read zero
// - indicator field: 00/11 usb, 01 owner plus speed, 10 basic owner
// - bit 0 enables string descriptor support
// - fixed-device bits 1..4 mark ports 1..4 non-removable
// - report non-removable active ports upstream
// - with defaults, two straps choose non-removable ports
// - self-powered: ports set in its mask stay disabled
// - bus-powered: ports set in its mask stay disabled
// - with defaults, two straps choose disabled ports
// - all four registers reset to zero
`timescale 1ns/1ps
`include "hub_cfg_regs.svh"
module hub_port_config_registers
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire hub_cfg_pkg::cfg_req_s req,
  input wire logic use_defaults,
  input wire logic compound_cfg,
  input wire logic self_powered,
  input wire logic apply_load,
  input wire logic [1:0] fixed_attachment_straps,
  input wire logic [1:0] port_off_straps,
  output logic [7:0] rdata,
  output logic rvalid,
  output hub_cfg_pkg::hub_settings_s settings,
  output logic [3:0] removable_report,
  output logic [3:0] port_enable_allowed,
  output logic settings_valid
);

  ////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] assign_led_string_config;
  logic [7:0] fixed_device_ports;
  logic [7:0] self_powered_port_off;
  logic [7:0] bus_powered_port_off;
  logic [3:0] straps_synced;
  logic [7:0] strap_fixed;
  logic [7:0] strap_off;
  logic [7:0] next_rdata;
  hub_cfg_pkg::hub_settings_s next_settings;
  logic [7:0] fixed_attachment_mask;
  logic [7:0] off_mask;
  logic write_cfg3;
  logic write_fixed;
  logic write_self_off;
  logic write_bus_off;
  hub_cfg_pkg::ownership_style_e next_style;
  hub_cfg_pkg::indicator_scheme_e next_scheme;
  logic next_compound;

  ////////////////////////////////////////////////////////////////////////
  // strap pins pass two flops first; they move with no regard to mclk

  strap_sync i_strap_sync
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pins({fixed_attachment_straps, port_off_straps}),
    .synced(straps_synced)
  );

  // code tables turn the synced straps into port masks
  strap_decode i_strap_decode
  (
    .fixed_code(straps_synced[3:2]),
    .off_code(straps_synced[1:0]),
    .fixed_mask(strap_fixed),
    .off_mask(strap_off)
  );

  ////////////////////////////////////////////////////////////////////////
  // write decode: one hit per register, none while frozen or unmapped

  always_comb
  begin
    write_cfg3 = 1'b0;
    write_fixed = 1'b0;
    write_self_off = 1'b0;
    write_bus_off = 1'b0;
    if (clk_en && req.wr)
    begin
      if (req.addr == `OFS_ASSIGN_LED_STRING_CONFIG)
      begin
        write_cfg3 = 1'b1;
      end
      else if (req.addr == `OFS_FIXED_DEVICE_PORTS)
      begin
        write_fixed = 1'b1;
      end
      else if (req.addr == `OFS_SELF_POWERED_PORT_OFF)
      begin
        write_self_off = 1'b1;
      end
      else if (req.addr == `OFS_BUS_POWERED_PORT_OFF)
      begin
        write_bus_off = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage; reserved bits are masked on the way in, so they can
  // never hold ones and always read back zero

  // style, source, indicator and string fields
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      assign_led_string_config <= `CFG_RESET;
    end
    else if (write_cfg3)
    begin
      assign_led_string_config <= req.wdata & `CFG3_MASK;
    end
  end

  // fixed-device ports, bits 1..4 only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fixed_device_ports <= `CFG_RESET;
    end
    else if (write_fixed)
    begin
      fixed_device_ports <= req.wdata & `PORT_MASK;
    end
  end

  // ports held off while self-powered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      self_powered_port_off <= `CFG_RESET;
    end
    else if (write_self_off)
    begin
      self_powered_port_off <= req.wdata & `PORT_MASK;
    end
  end

  // ports held off while bus-powered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_powered_port_off <= `CFG_RESET;
    end
    else if (write_bus_off)
    begin
      bus_powered_port_off <= req.wdata & `PORT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path; unmapped offsets answer zero

  always_comb
  begin
    if (req.addr == `OFS_ASSIGN_LED_STRING_CONFIG)
    begin
      next_rdata = assign_led_string_config;
    end
    else if (req.addr == `OFS_FIXED_DEVICE_PORTS)
    begin
      next_rdata = fixed_device_ports;
    end
    else if (req.addr == `OFS_SELF_POWERED_PORT_OFF)
    begin
      next_rdata = self_powered_port_off;
    end
    else if (req.addr == `OFS_BUS_POWERED_PORT_OFF)
    begin
      next_rdata = bus_powered_port_off;
    end
    else
    begin
      next_rdata = 8'h00;
    end
  end

  // read strobe answer, one cycle after the read edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid <= req.rd;
    end
  end

  // read data holds until the next read, giving the loader slack
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `CFG_RESET;
    end
    else if (clk_en && req.rd)
    begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of the settings image

  // straps replace the stored masks; power mode picks one of two off masks
  always_comb
  begin
    fixed_attachment_mask = use_defaults ? strap_fixed : fixed_device_ports;
    if (use_defaults)
    begin
      off_mask = strap_off;
    end
    else if (self_powered)
    begin
      off_mask = self_powered_port_off;
    end
    else
    begin
      off_mask = bus_powered_port_off;
    end
  end

  // one arm per style code keeps the field order in plain sight
  always_comb
  begin
    case (assign_led_string_config[`STYLE_MSB:`STYLE_LSB])
      2'b00: next_style = hub_cfg_pkg::style_programmable;
      2'b01: next_style = hub_cfg_pkg::style_direct_level;
      2'b10: next_style = hub_cfg_pkg::style_edge_no_unassigned;
      default: next_style = hub_cfg_pkg::style_edge_unassigned;
    endcase
  end

  // codes 00 and 11 both give plain usb indication
  always_comb
  begin
    case (assign_led_string_config[`INDICATOR_MSB:`INDICATOR_LSB])
      2'b01: next_scheme = hub_cfg_pkg::led_owner_speed;
      2'b10: next_scheme = hub_cfg_pkg::led_owner_basic;
      default: next_scheme = hub_cfg_pkg::led_usb;
    endcase
  end

  // straps imply compound whenever any port is fixed
  always_comb
  begin
    if (use_defaults)
    begin
      next_compound = |strap_fixed;
    end
    else
    begin
      next_compound = compound_cfg;
    end
  end

  // image handed to the hub core at the next load
  always_comb
  begin
    next_settings = '0;
    next_settings.style = next_style;
    next_settings.from_registers = assign_led_string_config[`SOURCE_BIT];
    next_settings.scheme = next_scheme;
    next_settings.string_enable = assign_led_string_config[`STRING_BIT];
    next_settings.fixed_ports = fixed_attachment_mask[4:1];
    next_settings.ports_off = off_mask[4:1];
    next_settings.compound = next_compound;
  end

  ////////////////////////////////////////////////////////////////////////
  // latched image: taken on apply_load only, so later writes cannot move
  // the hub under a running host

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settings <= '0;
    end
    else if (clk_en && apply_load)
    begin
      settings <= next_settings;
    end
  end

  // valid rises at the first load and stays up until reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settings_valid <= 1'b0;
    end
    else if (clk_en && apply_load)
    begin
      settings_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port qualifiers from the same load; a disabled port is not
  // active, so it never reports a fixed device upstream

  for (genvar p = 0; p < 4; p++)
  begin : g_port
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        removable_report[p] <= 1'b0;
        port_enable_allowed[p] <= 1'b0;
      end
      else if (clk_en && apply_load)
      begin
        removable_report[p] <= next_settings.fixed_ports[p] & ~next_settings.ports_off[p];
        port_enable_allowed[p] <= ~next_settings.ports_off[p];
      end
    end
  end

endmodule // hub_port_config_registers

/* File: testbench/hub_cfg_props.sv */
/*
  hub_cfg_props.sv: timing and relation checks on the config bank ports.
  assumes: bound to hub_port_config_registers, single mclk domain.
*/
`timescale 1ns/1ps
module hub_cfg_props
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire hub_cfg_pkg::cfg_req_s req,
  input wire logic use_defaults,
  input wire logic apply_load,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire hub_cfg_pkg::hub_settings_s settings,
  input wire logic [3:0] removable_report,
  input wire logic [3:0] port_enable_allowed,
  input wire logic settings_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic ld;
  // a load is only taken while enabled
  assign ld = clk_en && apply_load;
  // read answer one cycle after the strobe, reserved bits low
  // a frozen edge leaves the strobe where it was
  AST_RVALID: assert property (rvalid ==
    ($past(clk_en) ? $past(req.rd) : $past(rvalid))) else $error("read answer timing wrong");
  AST_RSVD: assert property (rvalid |-> (rdata & ~(($past(req.addr) == 8'h08) ?
    8'he7 : 8'h1e)) == 8'h00) else $error("reserved bit read high");
  // settings image follows loads only
  AST_LOAD: assert property (ld |=> settings_valid)
    else $error("load not marked valid");
  AST_STAY: assert property (settings_valid |=> settings_valid)
    else $error("valid dropped");
  AST_HOLD: assert property (!ld |=> $stable(settings))
    else $error("settings moved without load");
  AST_ALLOW: assert property (port_enable_allowed ==
    (settings_valid ? ~settings.ports_off : 4'h0)) else $error("enable mask wrong");
  AST_REPORT: assert property (removable_report ==
    (settings.fixed_ports & ~settings.ports_off)) else $error("removable report wrong");
  AST_SCHEME: assert property (settings.scheme != 2'b11)
    else $error("scheme code 11 not folded");
  AST_DEF_OFF: assert property (ld && use_defaults |=>
    settings.ports_off inside {4'h0, 4'h8, 4'hc, 4'he}) else $error("strap off mask");
  AST_DEF_COMP: assert property (ld && use_defaults |=>
    settings.compound == (|settings.fixed_ports)) else $error("strap compound");
endmodule // hub_cfg_props
bind hub_port_config_registers hub_cfg_props i_hub_cfg_props (.mclk(mclk), .rst_n(rst_n),
  .clk_en(clk_en), .req(req), .use_defaults(use_defaults), .apply_load(apply_load),
  .rdata(rdata), .rvalid(rvalid), .settings(settings), .removable_report(removable_report),
  .port_enable_allowed(port_enable_allowed), .settings_valid(settings_valid));

/* File: testbench/cfg_loader.sv */
/*
  cfg_loader.sv: behavioural config loader driving one-cycle byte strobes.
  assumes: strobes taken on rising mclk; released lines show inverted data.
*/
`timescale 1ns/1ps
module cfg_loader
(
  input wire logic mclk,
  output hub_cfg_pkg::cfg_req_s req
);
  initial req = '0;
  // one strobe cycle; indicator codes sent as given, all pins exist here
  task automatic put(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // off masks contiguous from port 4 downwards
  function automatic logic [7:0] off_mask(input int n);
    return (8'h1e << (4 - n)) & 8'h1e;
  endfunction
endmodule // cfg_loader

/* File: testbench/tb_top.sv */
/*
  tb_top.sv: directed test of the port configuration register bank.
  assumes: cfg_loader model drives the byte port; straps driven here.
*/
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic dflt = 1'b0;
  logic comp = 1'b0;
  logic selfp = 1'b1;
  logic ld = 1'b0;
  logic [1:0] fst = 2'b00;
  logic [1:0] ost = 2'b00;
  hub_cfg_pkg::cfg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  hub_cfg_pkg::hub_settings_s st;
  logic [3:0] rem;
  logic [3:0] allow;
  logic sv;
  int miscompares = 0;
  int checks = 0;
  cfg_loader i_cfg_loader (.mclk(mclk), .req(req));
  hub_port_config_registers i_hub_port_config_registers (.mclk(mclk), .rst_n(rst_n),
    .clk_en(clk_en), .req(req), .use_defaults(dflt), .compound_cfg(comp),
    .self_powered(selfp), .apply_load(ld), .fixed_attachment_straps(fst),
    .port_off_straps(ost), .rdata(rdata), .rvalid(rvalid), .settings(st),
    .removable_report(rem), .port_enable_allowed(allow), .settings_valid(sv));
  initial forever #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // read lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_cfg_loader.put(1'b0, 1'b1, a, 8'h00);
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", e, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cfg_loader.put(1'b1, 1'b0, a, d);
  endtask
  task automatic load();
    @(posedge mclk);
    ld <= 1'b1;
    @(posedge mclk);
    ld <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 8; i < 12; i++)
      rd(i[7:0], 8'h00);
    chk("valid", 8'h00, {7'h00, sv});
    // all ones into each place, one unmapped
    for (int i = 8; i < 13; i++)
    begin
      wr(i[7:0], 8'hff);
      rd(i[7:0], i == 8 ? 8'he7 : (i == 12 ? 8'h00 : 8'h1e));
    end
    // every style and indicator code, string on and off
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h08, {i[1:0], i[0], 2'b00, i[1:0] ^ 2'b01, i[1]});
      load();
      chk("valid_set", 8'h01, {7'h00, sv});
      chk("style", {6'h00, i[1:0]}, {6'h00, st.style});
      chk("source", {7'h00, i[0]}, {7'h00, st.from_registers});
      chk("scheme", (i ^ 1) == 3 ? 8'h00 : 8'(i ^ 1), {6'h00, st.scheme});
      chk("string", {7'h00, i[1]}, {7'h00, st.string_enable});
    end
    @(posedge mclk);
    comp <= 1'b1;
    wr(8'h09, 8'h06);
    wr(8'h0a, i_cfg_loader.off_mask(2));
    wr(8'h0b, i_cfg_loader.off_mask(1));
    load();
    chk("fixed", 8'h03, {4'h0, st.fixed_ports});
    chk("self_off", 8'h0c, {4'h0, st.ports_off});
    chk("allowed", 8'h03, {4'h0, allow});
    chk("compound", 8'h01, {7'h00, st.compound});
    @(posedge mclk);
    selfp <= 1'b0;
    wr(8'h09, 8'h1e);
    load();
    chk("bus_off", 8'h08, {4'h0, st.ports_off});
    chk("report", 8'h07, {4'h0, rem});
    // stored write without a load, then a frozen write
    wr(8'h09, 8'h00);
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(8'h0b, 8'h1e);
    clk_en <= 1'b1;
    #1;
    chk("held", 8'h0f, {4'h0, st.fixed_ports});
    rd(8'h0b, 8'h10);
    // strap defaults after synchroniser settles
    @(posedge mclk);
    dflt <= 1'b1;
    fst <= 2'b10;
    ost <= 2'b01;
    repeat (3) @(posedge mclk);
    load();
    chk("def_fixed", 8'h03, {4'h0, st.fixed_ports});
    chk("def_off", 8'h08, {4'h0, st.ports_off});
    chk("def_comp", 8'h01, {7'h00, st.compound});
    complete_run();
  end
  // run takes well under 30 us
  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule // tb_top
